// File: i2c_flags_defines.svh
// Register offsets, field positions and reset values of the status flag block
`ifndef I2C_FLAGS_DEFINES_SVH
`define I2C_FLAGS_DEFINES_SVH
`define OFF_STATUS 8'h00
`define OFF_CTRL 8'h04
`define OFF_TX_HOLD 8'h08
`define OFF_RX_HOLD 8'h0c
`define OFF_IRQ_STAT 8'h10
`define OFF_IRQ_MASK 8'h14
`define ST_NACK 15
`define ST_MTX 14
`define ST_ACKPH 13
`define ST_COLL 10
`define ST_GC 9
`define ST_TEN 8
`define ST_WCOL 7
`define ST_OVF 6
`define ST_DA 5
`define ST_STOP 4
`define ST_START 3
`define ST_RW 2
`define ST_RXF 1
`define ST_TXF 0
`define CT_MASTER 0
`define CT_SLAVE 1
`define CT_OVWR 2
`define CT_GCEN 3
`define CT_TENBIT 4
`define CT_ADDR_LO 8
`define CT_ADDR_HI 17
`define IRQ_RX 0
`define IRQ_TXDONE 1
`define IRQ_COLL 2
`define IRQ_STOP 3
`define IRQ_START 4
`define IRQ_W 5
`define BITS_PER_BYTE 4'h8
`define GC_ADDR 8'h00
`define TEN_HDR 5'h1e
`define CTRL_RST 32'h0000_0000
`endif

// File: i2c_flags_pkg.sv
// Types of the status flag block
`default_nettype none
package i2c_flags_pkg;
	typedef struct packed {
		logic scl_q;
		logic sda_q;
		logic in_frame;
		logic first_byte;
		logic pend_ten;
		logic addressed;
		logic ack_drive;
		logic [3:0] bit_cnt;
		logic [7:0] rx_shift_reg;
		logic [7:0] tx_holding_reg;
		logic [7:0] rx_holding_reg;
		logic [15:0] flags;
		logic [31:0] ctrl;
		logic [4:0] irq_stat;
		logic [4:0] irq_mask;
		logic [31:0] rdata;
		logic irq;
		logic sda_oe;
	} state_t;
endpackage
`default_nettype wire

// File: pin_sync.sv
// Two-stage synchroniser for a group of bus pins
`default_nettype none
module pin_sync #(
	parameter int WIDTH = 2
) (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic [WIDTH-1:0] pin_in,
	output var logic [WIDTH-1:0] pin_sync
);
	logic [WIDTH-1:0] meta_ff;
	logic [WIDTH-1:0] sync_ff;
	genvar gi;
	generate
		for (gi = 0; gi < WIDTH; gi++) begin : g_bit
			always_ff @(posedge clk) begin
				if (!rst_n) begin
					meta_ff[gi] <= 1'b1;
					sync_ff[gi] <= 1'b1;
				end else begin
					meta_ff[gi] <= pin_in[gi];
					sync_ff[gi] <= meta_ff[gi];
				end
			end
		end
	endgenerate
	assign pin_sync = sync_ff;
endmodule
`default_nettype wire

// File: i2c_flags.sv
// Status flag logic of a two-wire bus controller, master transmit and slave receive
//
// Overview of operation
// RL1: In master transmit the nack flag takes the acknowledge bit level at the end of the acknowledge.
// RL2: The master transmit flag rises when a master byte starts and falls at the end of its acknowledge.
// RL3: In slave mode the acknowledge phase flag sets on the 8th SCL fall and clears on the 9th rise.
// RL4: A bus collision during a master transmit sets the sticky master collision flag.
// RL5: A received general call address sets the general call flag and a Stop clears it.
// RL6: A matching second byte of a ten-bit address sets the ten-bit flag and a Stop clears it.
// RL7: A transmit holding write while busy is dropped and sets the write collision flag, cleared by software.
// RL8: A byte moved while the receive holding register is full sets the overflow flag, cleared by software.
// RL9: In slave mode an address match clears the data flag and a received data byte sets it.
// RL10: The stop flag is one only when a Stop was the latest bus condition seen.
// RL11: The start flag is one only when a Start or Repeated Start was the latest bus condition.
// RL12: After each slave address byte the direction flag takes the read or write bit.
// RL13: The receive full flag sets when a byte enters the receive holding register and clears on its read.
// RL14: The transmit full flag sets on a transmit holding write and clears when that byte is sent.
// RL15: Status bits 31 to 16 and 12 to 11 read as zero.
// RL16: Without the overwrite option the receive holding register updates only while overflow is clear.
// RL17: All status flags are zero after reset.
//
// The address map and the plain strobed port are this design's own decisions.
`default_nettype none
`include "i2c_flags_defines.svh"
module i2c_flags (
	input wire logic MCLK,
	input wire logic RSTN,
	input wire logic [7:0] ADDR,
	input wire logic [31:0] WDATA,
	input wire logic WR,
	input wire logic RD,
	output var logic [31:0] RDATA,
	input wire logic SCL_IN,
	input wire logic SDA_IN,
	output var logic SDA_OUT,
	output var logic SDA_OE,
	output var logic IRQ
);
	i2c_flags_pkg::state_t st_ff;
	i2c_flags_pkg::state_t nxt_st;
	logic [1:0] pins;
	logic scl;
	logic sda;
	logic scl_rise;
	logic scl_fall;
	logic start_det;
	logic stop_det;
	logic data_rise;
	logic ack_rise;
	logic tx_bit;
	logic coll_evt;
	logic byte_done;
	logic [7:0] rx_byte;
	logic tx_wr;
	logic busy;
	logic rx_rd;

	function automatic logic reg_hit(input logic [7:0] a, input logic [7:0] off);
		reg_hit = (a == off);
	endfunction

	pin_sync #(.WIDTH(2)) u_sync (
		.clk(MCLK),
		.rst_n(RSTN),
		.pin_in({SDA_IN, SCL_IN}),
		.pin_sync(pins)
	);

	assign scl = pins[0];
	assign sda = pins[1];
	assign scl_rise = scl & ~st_ff.scl_q;
	assign scl_fall = ~scl & st_ff.scl_q;
	assign start_det = scl & st_ff.scl_q & st_ff.sda_q & ~sda;
	assign stop_det = scl & st_ff.scl_q & ~st_ff.sda_q & sda;
	assign data_rise = scl_rise & st_ff.in_frame & (st_ff.bit_cnt < `BITS_PER_BYTE);
	assign ack_rise = scl_rise & st_ff.in_frame & (st_ff.bit_cnt == `BITS_PER_BYTE);
	assign tx_bit = st_ff.tx_holding_reg[3'h7 - st_ff.bit_cnt[2:0]];
	assign coll_evt = data_rise & st_ff.flags[`ST_MTX] & tx_bit & ~sda;
	assign byte_done = data_rise & (st_ff.bit_cnt == 4'h7);
	assign rx_byte = {st_ff.rx_shift_reg[6:0], sda};
	assign tx_wr = WR & reg_hit(ADDR, `OFF_TX_HOLD);
	assign busy = st_ff.flags[`ST_MTX] | st_ff.flags[`ST_TXF];
	assign rx_rd = RD & reg_hit(ADDR, `OFF_RX_HOLD);

	always_comb begin
		logic move;
		logic upd;
		logic slave_ok;
		logic [9:0] own;
		logic [4:0] ev;
		logic [15:0] rd_stat;
		move = 1'b0;
		upd = 1'b0;
		ev = 5'h00;
		rd_stat = 16'h0000;
		own = st_ff.ctrl[`CT_ADDR_HI:`CT_ADDR_LO];
		slave_ok = st_ff.ctrl[`CT_SLAVE] & ~st_ff.flags[`ST_MTX];
		nxt_st = st_ff;
		nxt_st.scl_q = scl;
		nxt_st.sda_q = sda;
		nxt_st.rdata = 32'h0000_0000;
		// Software side: clears first, so hardware sets below win
		if (WR) begin
			if (reg_hit(ADDR, `OFF_STATUS)) begin
				if (WDATA[`ST_WCOL]) nxt_st.flags[`ST_WCOL] = 1'b0; // [RL7]
				if (WDATA[`ST_OVF]) nxt_st.flags[`ST_OVF] = 1'b0; // [RL8]
				if (WDATA[`ST_COLL]) nxt_st.flags[`ST_COLL] = 1'b0;
			end
			if (reg_hit(ADDR, `OFF_CTRL)) begin
				nxt_st.ctrl = WDATA;
			end
			if (reg_hit(ADDR, `OFF_IRQ_STAT)) begin
				nxt_st.irq_stat = st_ff.irq_stat & ~WDATA[`IRQ_W-1:0];
			end
			if (reg_hit(ADDR, `OFF_IRQ_MASK)) begin
				nxt_st.irq_mask = WDATA[`IRQ_W-1:0];
			end
		end
		if (rx_rd) begin
			nxt_st.flags[`ST_RXF] = 1'b0; // [RL13]
		end
		if (tx_wr) begin
			if (busy) begin
				nxt_st.flags[`ST_WCOL] = 1'b1; // [RL7]
			end else begin
				nxt_st.tx_holding_reg = WDATA[7:0];
				nxt_st.flags[`ST_TXF] = 1'b1; // [RL14]
				if (st_ff.ctrl[`CT_MASTER]) begin
					nxt_st.flags[`ST_MTX] = 1'b1; // [RL2]
					nxt_st.sda_oe = ~WDATA[7];
				end
			end
		end
		// Bus conditions
		if (start_det) begin
			nxt_st.flags[`ST_START] = 1'b1; // [RL11]
			nxt_st.flags[`ST_STOP] = 1'b0; // [RL10]
			nxt_st.in_frame = 1'b1;
			nxt_st.first_byte = 1'b1;
			nxt_st.addressed = 1'b0;
			nxt_st.ack_drive = 1'b0;
			nxt_st.bit_cnt = 4'h0;
			nxt_st.sda_oe = 1'b0;
			ev[`IRQ_START] = 1'b1;
		end else if (stop_det) begin
			nxt_st.flags[`ST_STOP] = 1'b1; // [RL10]
			nxt_st.flags[`ST_START] = 1'b0; // [RL11]
			nxt_st.flags[`ST_GC] = 1'b0; // [RL5]
			nxt_st.flags[`ST_TEN] = 1'b0; // [RL6]
			nxt_st.flags[`ST_ACKPH] = 1'b0;
			nxt_st.in_frame = 1'b0;
			nxt_st.pend_ten = 1'b0;
			nxt_st.addressed = 1'b0;
			nxt_st.ack_drive = 1'b0;
			nxt_st.bit_cnt = 4'h0;
			nxt_st.sda_oe = 1'b0;
			ev[`IRQ_STOP] = 1'b1;
		end else begin
			if (data_rise) begin
				nxt_st.rx_shift_reg = rx_byte;
				nxt_st.bit_cnt = st_ff.bit_cnt + 4'h1;
			end
			if (coll_evt) begin
				// Lost arbitration: release the line and drop the byte
				nxt_st.flags[`ST_COLL] = 1'b1; // [RL4]
				nxt_st.flags[`ST_MTX] = 1'b0;
				nxt_st.flags[`ST_TXF] = 1'b0;
				nxt_st.sda_oe = 1'b0;
				ev[`IRQ_COLL] = 1'b1;
			end
			if (byte_done && slave_ok) begin
				nxt_st.first_byte = 1'b0;
				nxt_st.ack_drive = 1'b0;
				if (st_ff.first_byte) begin
					if (rx_byte == `GC_ADDR && st_ff.ctrl[`CT_GCEN]) begin
						nxt_st.flags[`ST_GC] = 1'b1; // [RL5]
						nxt_st.addressed = 1'b1;
						nxt_st.flags[`ST_DA] = 1'b0; // [RL9]
						nxt_st.flags[`ST_RW] = 1'b0; // [RL12]
						move = 1'b1;
					end else if (st_ff.ctrl[`CT_TENBIT]) begin
						if (rx_byte[7:3] == `TEN_HDR && rx_byte[2:1] == own[9:8]) begin
							nxt_st.flags[`ST_RW] = rx_byte[0]; // [RL12]
							nxt_st.ack_drive = 1'b1;
							// Read header after a full match re-addresses at once
							if (rx_byte[0] && st_ff.flags[`ST_TEN]) begin
								nxt_st.addressed = 1'b1;
								nxt_st.flags[`ST_DA] = 1'b0; // [RL9]
							end else begin
								nxt_st.pend_ten = 1'b1;
							end
						end
					end else if (rx_byte[7:1] == own[6:0]) begin
						nxt_st.addressed = 1'b1;
						nxt_st.flags[`ST_DA] = 1'b0; // [RL9]
						nxt_st.flags[`ST_RW] = rx_byte[0]; // [RL12]
						move = 1'b1;
					end
				end else if (st_ff.pend_ten) begin
					nxt_st.pend_ten = 1'b0;
					if (rx_byte == own[7:0]) begin
						nxt_st.flags[`ST_TEN] = 1'b1; // [RL6]
						nxt_st.addressed = 1'b1;
						nxt_st.flags[`ST_DA] = 1'b0; // [RL9]
						move = 1'b1;
					end
				end else if (st_ff.addressed) begin
					nxt_st.flags[`ST_DA] = 1'b1; // [RL9]
					move = 1'b1;
				end
			end else if (byte_done) begin
				nxt_st.first_byte = 1'b0;
			end
			if (move) begin
				// Overwrite option ignores overflow but never a full holding register
				upd = ~st_ff.flags[`ST_RXF] &
					(st_ff.ctrl[`CT_OVWR] | ~st_ff.flags[`ST_OVF]); // [RL16]
				if (st_ff.flags[`ST_RXF]) begin
					nxt_st.flags[`ST_OVF] = 1'b1; // [RL8]
				end
				if (upd) begin
					nxt_st.rx_holding_reg = rx_byte;
					nxt_st.flags[`ST_RXF] = 1'b1; // [RL13]
					nxt_st.ack_drive = 1'b1;
					ev[`IRQ_RX] = 1'b1;
				end
			end
			if (ack_rise) begin
				nxt_st.bit_cnt = 4'h0;
				nxt_st.flags[`ST_ACKPH] = 1'b0; // [RL3]
				if (st_ff.flags[`ST_MTX]) begin
					nxt_st.flags[`ST_NACK] = sda; // [RL1]
					nxt_st.flags[`ST_MTX] = 1'b0; // [RL2]
					nxt_st.flags[`ST_TXF] = 1'b0; // [RL14]
					ev[`IRQ_TXDONE] = 1'b1;
				end
			end
			if (scl_fall && st_ff.in_frame) begin
				if (st_ff.bit_cnt == `BITS_PER_BYTE && st_ff.ctrl[`CT_SLAVE]) begin
					nxt_st.flags[`ST_ACKPH] = 1'b1; // [RL3]
				end
				// Line changes only while SCL is low
				if (st_ff.flags[`ST_MTX] && st_ff.bit_cnt < `BITS_PER_BYTE) begin
					nxt_st.sda_oe = ~tx_bit;
				end else begin
					nxt_st.sda_oe = st_ff.ack_drive & (st_ff.bit_cnt == `BITS_PER_BYTE);
				end
			end
		end
		nxt_st.irq_stat = nxt_st.irq_stat | ev;
		nxt_st.irq = |(nxt_st.irq_stat & nxt_st.irq_mask);
		rd_stat = st_ff.flags;
		rd_stat[12:11] = 2'h0; // [RL15]
		if (RD) begin
			if (reg_hit(ADDR, `OFF_STATUS)) nxt_st.rdata = {16'h0000, rd_stat}; // [RL15]
			if (reg_hit(ADDR, `OFF_CTRL)) nxt_st.rdata = st_ff.ctrl;
			if (reg_hit(ADDR, `OFF_TX_HOLD)) nxt_st.rdata = {24'h00_0000, st_ff.tx_holding_reg};
			if (reg_hit(ADDR, `OFF_RX_HOLD)) nxt_st.rdata = {24'h00_0000, st_ff.rx_holding_reg};
			if (reg_hit(ADDR, `OFF_IRQ_STAT)) nxt_st.rdata = {27'h000_0000, st_ff.irq_stat};
			if (reg_hit(ADDR, `OFF_IRQ_MASK)) nxt_st.rdata = {27'h000_0000, st_ff.irq_mask};
		end
	end

	always_ff @(posedge MCLK) begin
		if (!RSTN) begin
			st_ff <= '0; // [RL17]
			// Pins idle high, so no false edge after reset
			st_ff.scl_q <= 1'b1;
			st_ff.sda_q <= 1'b1;
		end else begin
			st_ff <= nxt_st;
		end
	end

	assign RDATA = st_ff.rdata;
	assign SDA_OUT = 1'b0;
	assign SDA_OE = st_ff.sda_oe;
	assign IRQ = st_ff.irq;

	sequence s_tx_write_ok;
		tx_wr && !busy && !start_det && !stop_det && !coll_evt;
	endsequence

	sequence s_slave_ack_start;
		scl_fall && st_ff.in_frame && !start_det && !stop_det &&
			st_ff.ctrl[`CT_SLAVE] && st_ff.bit_cnt == `BITS_PER_BYTE;
	endsequence

	property p_nack_result;
		@(posedge MCLK) disable iff (!RSTN)
		ack_rise && st_ff.flags[`ST_MTX] && !start_det && !stop_det
			|=> st_ff.flags[`ST_NACK] == $past(sda) && !st_ff.flags[`ST_MTX];
	endproperty
	a_nack_result: assert property (p_nack_result) else $error("nack flag wrong after ack"); // [RL1]

	property p_mtx_start;
		@(posedge MCLK) disable iff (!RSTN)
		s_tx_write_ok ##0 st_ff.ctrl[`CT_MASTER] |=> st_ff.flags[`ST_MTX] && st_ff.flags[`ST_TXF];
	endproperty
	a_mtx_start: assert property (p_mtx_start) else $error("master transmit not started"); // [RL2]

	property p_ack_phase;
		@(posedge MCLK) disable iff (!RSTN)
		s_slave_ack_start |=> st_ff.flags[`ST_ACKPH];
	endproperty
	a_ack_phase: assert property (p_ack_phase) else $error("ack phase flag not set"); // [RL3]

	property p_ack_clear;
		@(posedge MCLK) disable iff (!RSTN)
		ack_rise && !start_det && !stop_det |=> !st_ff.flags[`ST_ACKPH];
	endproperty
	a_ack_clear: assert property (p_ack_clear) else $error("ack phase flag not cleared"); // [RL3]

	property p_collision;
		@(posedge MCLK) disable iff (!RSTN)
		coll_evt && !start_det && !stop_det |=> st_ff.flags[`ST_COLL] && !SDA_OE;
	endproperty
	a_collision: assert property (p_collision) else $error("collision not flagged"); // [RL4]

	property p_stop_clears;
		@(posedge MCLK) disable iff (!RSTN)
		stop_det |=> !st_ff.flags[`ST_GC] && !st_ff.flags[`ST_TEN] &&
			st_ff.flags[`ST_STOP] && !st_ff.flags[`ST_START];
	endproperty
	a_stop_clears: assert property (p_stop_clears) else $error("stop did not update flags"); // [RL5]

	property p_start_flag;
		@(posedge MCLK) disable iff (!RSTN)
		start_det |=> st_ff.flags[`ST_START] && !st_ff.flags[`ST_STOP];
	endproperty
	a_start_flag: assert property (p_start_flag) else $error("start did not update flags"); // [RL11]

	property p_wr_collision;
		@(posedge MCLK) disable iff (!RSTN)
		tx_wr && busy |=> st_ff.flags[`ST_WCOL] && $stable(st_ff.tx_holding_reg);
	endproperty
	a_wr_collision: assert property (p_wr_collision) else $error("busy write not rejected"); // [RL7]

	property p_overflow;
		@(posedge MCLK) disable iff (!RSTN)
		byte_done && st_ff.flags[`ST_RXF] && !rx_rd && !start_det && !stop_det
			|=> $stable(st_ff.rx_holding_reg);
	endproperty
	a_overflow: assert property (p_overflow) else $error("full holding register overwritten"); // [RL16]

	property p_rx_read;
		@(posedge MCLK) disable iff (!RSTN)
		rx_rd && !byte_done |=> !st_ff.flags[`ST_RXF];
	endproperty
	a_rx_read: assert property (p_rx_read) else $error("receive full not cleared"); // [RL13]

	property p_zero_bits;
		@(posedge MCLK) disable iff (!RSTN)
		RD && reg_hit(ADDR, `OFF_STATUS) |=> RDATA[31:16] == 16'h0000 && RDATA[12:11] == 2'h0;
	endproperty
	a_zero_bits: assert property (p_zero_bits) else $error("unimplemented bits not zero"); // [RL15]

	property p_tx_full;
		@(posedge MCLK) disable iff (!RSTN)
		s_tx_write_ok |=> st_ff.flags[`ST_TXF] && st_ff.tx_holding_reg == $past(WDATA[7:0]);
	endproperty
	a_tx_full: assert property (p_tx_full) else $error("transmit full not set"); // [RL14]
endmodule
`default_nettype wire

// File: i2c_bus_agent.sv
// Far-side bus agent: drives the bus clock and pulls the data line low
`default_nettype none
module i2c_bus_agent (
	input wire logic oe,
	output var logic scl,
	output wire logic sda
);
	timeunit 1ns;
	timeprecision 1ps;
	logic pull = 1'b0;
	int q = 40;
	initial begin
		scl = 1'b1;
	end
	// Wired line with pull-up, low while either party pulls
	assign sda = ~(oe | pull);
	task start_cond;
		pull = 1'b1;
		#q scl = 1'b0;
		#q pull = 1'b0;
		#q;
	endtask
	task stop_cond;
		pull = 1'b1;
		#q scl = 1'b1;
		#q pull = 1'b0;
		#q;
	endtask
	// One bus clock of 160 ns; data changes only while the clock is low
	task clk_bit(input logic b, output logic s);
		pull = ~b;
		#q scl = 1'b1;
		#q s = sda;
		#q scl = 1'b0;
		#q;
	endtask
	task bits(input logic [7:0] t, output logic [7:0] r);
		for (int i = 7; i >= 0; i--) begin
			clk_bit(t[i], r[i]);
		end
	endtask
endmodule
`default_nettype wire

// File: i2c_flags_bench.sv
// Self-checking bench of the status flag block with a far-side bus agent
`default_nettype none
`include "i2c_flags_defines.svh"
`define CHK(n, e, g) begin \
	compares++; \
	if ((g) !== (e)) begin \
		n_errors++; \
		$display("Error %s expected %h seen %h", n, e, g); \
	end \
end
module i2c_flags_bench;
	timeunit 1ns;
	timeprecision 1ps;
	logic MCLK = 1'b0;
	logic RSTN = 1'b0;
	logic [7:0] ADDR = 8'h00;
	logic [31:0] WDATA = 32'h0;
	logic WR = 1'b0;
	logic RD = 1'b0;
	logic [31:0] RDATA;
	logic SDA_OE;
	logic SDA_OUT;
	logic IRQ;
	wire logic SCL;
	wire logic SDA;
	int n_errors = 0;
	int compares = 0;
	logic [31:0] s;
	logic [7:0] r;
	logic a;
	always #2 MCLK = ~MCLK;
	i2c_flags u_dut (.MCLK(MCLK), .RSTN(RSTN), .ADDR(ADDR), .WDATA(WDATA), .WR(WR), .RD(RD),
		.RDATA(RDATA), .SCL_IN(SCL), .SDA_IN(SDA), .SDA_OUT(SDA_OUT), .SDA_OE(SDA_OE), .IRQ(IRQ));
	i2c_bus_agent u_agent (.oe(SDA_OE), .scl(SCL), .sda(SDA));
	task wr(input logic [7:0] ad, input logic [31:0] d);
		@(posedge MCLK);
		ADDR <= ad;
		WDATA <= d;
		WR <= 1'b1;
		@(posedge MCLK);
		WR <= 1'b0;
	endtask
	task rd(input logic [7:0] ad, output logic [31:0] d);
		@(posedge MCLK);
		ADDR <= ad;
		RD <= 1'b1;
		@(posedge MCLK);
		RD <= 1'b0;
		#1 d = RDATA;
	endtask
	task rs;
		rd(`OFF_STATUS, s);
	endtask
	// Byte into the slave, then the acknowledge clock; expected line level given
	task byte_in(input logic [7:0] b, input logic ack);
		u_agent.bits(b, r);
		u_agent.clk_bit(1'b1, a);
		`CHK("ack", ack, a)
	endtask
	task give_verdict;
		$display("compares %0d n_errors %0d", compares, n_errors);
		if (n_errors == 0 && compares > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask
	task t_reset;
		rs;
		`CHK("status", 32'h0, s)
		@(posedge MCLK);
		#1;
		`CHK("rdata idle", 32'h0, RDATA)
		`CHK("sda out", 1'b0, SDA_OUT)
		`CHK("sda oe", 1'b0, SDA_OE)
		rd(8'h40, s);
		`CHK("unmapped", 32'h0, s)
	endtask
	task t_slave;
		wr(`OFF_CTRL, 32'h0000_5502);
		u_agent.start_cond;
		rs;
		`CHK("start", 1'b1, s[`ST_START])
		`CHK("stop", 1'b0, s[`ST_STOP])
		u_agent.bits(8'haa, r);
		rs;
		`CHK("ackph on", 1'b1, s[`ST_ACKPH])
		u_agent.clk_bit(1'b1, a);
		`CHK("addr ack", 1'b0, a)
		rs;
		`CHK("ackph off", 1'b0, s[`ST_ACKPH])
		`CHK("da addr", 1'b0, s[`ST_DA])
		`CHK("rw", 1'b0, s[`ST_RW])
		`CHK("rxf", 1'b1, s[`ST_RXF])
		`CHK("unused", 18'h0, {s[31:16], s[12:11]})
		rd(`OFF_RX_HOLD, s);
		`CHK("rx addr", 8'haa, s[7:0])
		rs;
		`CHK("rxf rd", 1'b0, s[`ST_RXF])
		byte_in(8'h3c, 1'b0);
		rs;
		`CHK("da data", 1'b1, s[`ST_DA])
		byte_in(8'h5a, 1'b1);
		rs;
		`CHK("ovf", 1'b1, s[`ST_OVF])
		rd(`OFF_RX_HOLD, s);
		`CHK("rx kept", 8'h3c, s[7:0])
		byte_in(8'h77, 1'b1);
		rs;
		`CHK("rxf ovf", 1'b0, s[`ST_RXF])
		`CHK("ovf held", 1'b1, s[`ST_OVF])
		wr(`OFF_CTRL, 32'h0000_5506);
		byte_in(8'h66, 1'b0);
		rd(`OFF_RX_HOLD, s);
		`CHK("rx ovwr", 8'h66, s[7:0])
		wr(`OFF_STATUS, 32'h1 << `ST_OVF);
		wr(`OFF_IRQ_STAT, 32'h1f);
		wr(`OFF_IRQ_MASK, 32'h1 << `IRQ_STOP);
		rs;
		`CHK("ovf clr", 1'b0, s[`ST_OVF])
		`CHK("irq masked", 1'b0, IRQ)
		u_agent.stop_cond;
		rs;
		`CHK("stop", 1'b1, s[`ST_STOP])
		`CHK("start off", 1'b0, s[`ST_START])
		`CHK("irq", 1'b1, IRQ)
		wr(`OFF_IRQ_STAT, 32'h1f);
		rs;
		`CHK("irq clr", 1'b0, IRQ)
		u_agent.start_cond;
		byte_in(8'hab, 1'b0);
		rs;
		`CHK("rw read", 1'b1, s[`ST_RW])
		u_agent.stop_cond;
		rd(`OFF_RX_HOLD, s);
	endtask
	task t_gc;
		wr(`OFF_CTRL, 32'h0000_000a);
		u_agent.start_cond;
		byte_in(8'h00, 1'b0);
		rs;
		`CHK("gc", 1'b1, s[`ST_GC])
		u_agent.stop_cond;
		rs;
		`CHK("gc stop", 1'b0, s[`ST_GC])
		rd(`OFF_RX_HOLD, s);
	endtask
	task t_ten;
		wr(`OFF_CTRL, 32'h0002_a512);
		u_agent.start_cond;
		byte_in(8'hf4, 1'b0);
		byte_in(8'ha5, 1'b0);
		rs;
		`CHK("ten", 1'b1, s[`ST_TEN])
		u_agent.stop_cond;
		rs;
		`CHK("ten stop", 1'b0, s[`ST_TEN])
		rd(`OFF_RX_HOLD, s);
	endtask
	task t_mtx;
		wr(`OFF_CTRL, 32'h1);
		u_agent.start_cond;
		wr(`OFF_TX_HOLD, 32'hc3);
		rs;
		`CHK("mtx", 1'b1, s[`ST_MTX])
		`CHK("txf", 1'b1, s[`ST_TXF])
		wr(`OFF_TX_HOLD, 32'h11);
		rs;
		`CHK("wcol", 1'b1, s[`ST_WCOL])
		u_agent.bits(8'hff, r);
		`CHK("tx byte", 8'hc3, r)
		rs;
		`CHK("mtx ack", 1'b1, s[`ST_MTX])
		u_agent.clk_bit(1'b1, a);
		rs;
		`CHK("nack", 1'b1, s[`ST_NACK])
		`CHK("mtx end", 1'b0, s[`ST_MTX])
		`CHK("txf end", 1'b0, s[`ST_TXF])
		`CHK("wcol held", 1'b1, s[`ST_WCOL])
		wr(`OFF_STATUS, 32'h1 << `ST_WCOL);
		wr(`OFF_TX_HOLD, 32'h3c);
		rs;
		`CHK("wcol clr", 1'b0, s[`ST_WCOL])
		u_agent.bits(8'hff, r);
		u_agent.clk_bit(1'b0, a);
		rs;
		`CHK("ack seen", 1'b0, s[`ST_NACK])
		u_agent.stop_cond;
	endtask
	task t_coll;
		u_agent.start_cond;
		wr(`OFF_TX_HOLD, 32'h80);
		u_agent.clk_bit(1'b0, a);
		rs;
		`CHK("coll", 1'b1, s[`ST_COLL])
		`CHK("coll mtx", 1'b0, s[`ST_MTX])
		wr(`OFF_STATUS, 32'h1 << `ST_COLL);
		rs;
		`CHK("coll clr", 1'b0, s[`ST_COLL])
		u_agent.stop_cond;
	endtask
	initial begin
		#200000;
		n_errors++;
		give_verdict;
	end
	initial begin
		repeat (3) @(posedge MCLK);
		RSTN <= 1'b1;
		t_reset;
		t_slave;
		t_gc;
		t_ten;
		t_mtx;
		t_coll;
		give_verdict;
	end
endmodule
`default_nettype wire
